// ===== esdc_capture.v
// Serial data capture from an external bit clock or symbol marker.
//
// Behaviour
// R01 - Source raises bit clock at the start of every data bit; esdc_src holds the bit clock low in symbol mode.
// R02 - Normal mode samples data and marker on each bit clock fall.
// R03 - Bit clock, marker and data rate stay at or below 50 MHz; the 50 MHz capture clock resolves only up to 12.5 MHz.
// R04 - Marker may repeat per symbol or be a single one-bit pulse.
// R05 - Source holds marker high during the first bit of a symbol.
// R06 - Source keeps marker stable across each bit clock fall.
// R07 - Symbol mode samples data on each falling marker edge.
// R08 - High data level is logic one, low level is logic zero.
// R09 - Source presents valid data at every active falling edge.
// R10 - Marker high at a normal-mode sample restarts the bit count.
`timescale 1ns/1ps
`include "esdc_map.vh"
module esdc_capture #(
	parameter CNT_W = `ESDC_BITCNT_W
) (
	clk,
	nrst,
	symbol_mode,
	bit_clk_pin,
	data_pin,
	marker_pin,
	bit_valid,
	bit_value,
	bit_first,
	bit_index,
	aligned
);
	input  wire             clk;
	input  wire             nrst;
	input  wire             symbol_mode;
	input  wire             bit_clk_pin;
	input  wire             data_pin;
	input  wire             marker_pin;
	output reg              bit_valid;
	output reg              bit_value;
	output reg              bit_first;
	output reg  [CNT_W-1:0] bit_index;
	output reg              aligned;

	wire clk_level;
	wire clk_fall;
	wire dat_level;
	wire mrk_level;
	wire mrk_fall;
	reg  mode_reg;
	reg  [CNT_W-1:0] cnt_reg;
	reg  [CNT_W-1:0] cnt_next;
	reg  take;
	reg  first;

	// Bit clock edges, seen on the 50 MHz clock.
	esdc_sync u_clk (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (bit_clk_pin),
		.level (clk_level),
		.fall  (clk_fall)
	);

	// Data line; its level is taken together with the active edge.
	esdc_sync u_dat (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (data_pin),
		.level (dat_level),
		.fall  ()
	);

	// Marker, used as level in normal mode and as clock in symbol mode.
	esdc_sync u_mrk (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (marker_pin),
		.level (mrk_level),
		.fall  (mrk_fall)
	);

	// Mode select is a same-domain level, registered so a change mid-bit
	// cannot split one sample into two.
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			mode_reg <= `ESDC_MODE_NORMAL;
		else
			mode_reg <= symbol_mode;
	end

	// Pick the active edge and decide whether this bit opens a symbol.
	// The system clock only resolves link edges up to a quarter of its
	// rate, so a full 50 MHz stream needs a faster capture clock.
	always @* begin
		take     = 1'h0;
		first    = 1'h0;
		cnt_next = cnt_reg;
		if (mode_reg == `ESDC_MODE_SYMBOL) begin
			take = mrk_fall; // R07 R03
			first = mrk_fall;
		end else begin
			take = clk_fall; // R02 R03
			first = clk_fall & mrk_level; // R04 R06
		end
		if (take) begin
			if (first)
				cnt_next = {CNT_W{1'h0}}; // R10
			else
				cnt_next = cnt_reg + 1'h1;
		end
	end

	// Outputs all come from flip-flops; valid is a one-cycle pulse.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg   <= {CNT_W{1'h0}};
			bit_valid <= 1'h0;
			bit_value <= 1'h0;
			bit_first <= 1'h0;
			bit_index <= {CNT_W{1'h0}};
			aligned   <= 1'h0;
		end else begin
			bit_valid <= take;
			if (take) begin
				cnt_reg   <= cnt_next;
				bit_value <= dat_level; // R08
				bit_first <= first;
				bit_index <= cnt_next;
				if (first)
					aligned <= 1'h1; // R04
			end
		end
	end
endmodule // esdc_capture

// ===== esdc_capture_assertions.sv
// Port checker for the capture block.
`timescale 1ns/1ps
module esdc_chk #(parameter CNT_W = 8) (
	input wire clk, nrst, symbol_mode, bit_clk_pin, data_pin, marker_pin,
	input wire bit_valid, bit_value, bit_first, aligned,
	input wire [CNT_W-1:0] bit_index
);
	// One clock domain, so clocking and reset are given once.
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_nrm;
		!symbol_mode && $fell(bit_clk_pin) |-> ##[3:6] bit_valid;
	endproperty
	a_nrm: assert property (p_nrm) else $error("bit lost");
	property p_sym;
		symbol_mode && $fell(marker_pin) |-> ##[3:6] bit_valid && bit_first;
	endproperty
	a_sym: assert property (p_sym) else $error("symbol bit lost");
	property p_val; bit_valid |-> bit_value == $past(data_pin, 5); endproperty
	a_val: assert property (p_val) else $error("bad value");
	property p_mrk;
		bit_valid && !symbol_mode |-> bit_first == $past(marker_pin, 5);
	endproperty
	a_mrk: assert property (p_mrk) else $error("bad marker");
	property p_cnt;
		bit_valid |-> (bit_first ? bit_index == 0 : bit_index ==
			$past(bit_index) + 1'h1);
	endproperty
	a_cnt: assert property (p_cnt) else $error("bad index");
	property p_aln; bit_valid && bit_first || aligned |=> aligned; endproperty
	a_aln: assert property (p_aln) else $error("lost alignment");
	cover property (bit_valid && !bit_first && !symbol_mode);
	cover property (bit_valid && bit_first && !symbol_mode);
	cover property (bit_valid && symbol_mode);
endmodule // esdc_chk
bind esdc_capture esdc_chk #(.CNT_W(CNT_W)) u_chk (.*);

// ===== esdc_map.vh
// Constants for the external serial data capture block.
`ifndef ESDC_MAP_VH
`define ESDC_MAP_VH
`define ESDC_CLK_MHZ        50
`define ESDC_MAX_RATE_MHZ   50
`define ESDC_MODE_NORMAL    1'h0
`define ESDC_MODE_SYMBOL    1'h1
`define ESDC_BITCNT_W       8
`define ESDC_SYNC_STAGES    3
`endif

// ===== esdc_source.sv
// Behavioural serial source driving the capture pins.
`timescale 1ns/1ps
module esdc_src (
	output reg bclk = 1'h0,
	output reg data = 1'h0,
	output reg mark = 1'h0
);
	// Each bit opens on a rise and holds across the fall; 160 ns bits.
	task send(input [7:0] d, m, input sym, input integer n);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1) begin
				data = d[i];
				mark = sym | m[i];
				bclk = !sym;
				#80 bclk = 1'h0;
				if (sym) mark = 1'h0;
				#80;
			end
			mark = 1'h0;
			data = !data;
		end
	endtask
endmodule // esdc_src

// ===== esdc_sync.v
// Three-stage pin synchroniser with falling-edge detection.
`timescale 1ns/1ps
module esdc_sync (
	clk,
	nrst,
	pin,
	level,
	fall
);
	input  wire clk;
	input  wire nrst;
	input  wire pin;
	output reg  level;
	output reg  fall;

	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	// Stage one feeds only stage two; a change counts once two and three agree.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= 1'h0;
			s2_reg <= 1'h0;
			s3_reg <= 1'h0;
			level  <= 1'h0;
			fall   <= 1'h0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			fall   <= 1'h0;
			if (s2_reg == s3_reg) begin
				level <= s3_reg;
				fall  <= level & ~s3_reg;
			end
		end
	end
endmodule // esdc_sync

// ===== tb_esdc_capture.sv
// Self-checking bench for the capture block.
`timescale 1ns/1ps
module tb_esdc_capture;
	reg clk = 1'h0, nrst = 1'h0, symbol_mode = 1'h0;
	wire bclk, data, mark, bit_valid, bit_value, bit_first, aligned;
	wire [7:0] bit_index;
	integer n_errors = 0, num_checks = 0, cyc = 0, nb = 0, i;
	reg [9:0] got [0:15];
	// Normal-mode pattern: data bits and marker bits, sent LSB first.
	localparam [7:0] NRM_D = 8'hB4;
	localparam [7:0] NRM_M = 8'h21;
	always #10 clk = !clk;
	esdc_src u_src (.bclk(bclk), .data(data), .mark(mark));
	esdc_capture u_dut (.clk(clk), .nrst(nrst), .symbol_mode(symbol_mode),
		.bit_clk_pin(bclk), .data_pin(data), .marker_pin(mark),
		.bit_valid(bit_valid), .bit_value(bit_value), .bit_first(bit_first),
		.bit_index(bit_index), .aligned(aligned));
	// Log bits mid-cycle so the launching edge has settled.
	always @(negedge clk) if (bit_valid) begin
		got[nb % 16] = {bit_value, bit_first, bit_index};
		nb = nb + 1;
	end
	// A hang is cut short after far more cycles than the tests need.
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			n_errors = n_errors + 1;
			summarize;
		end
	end
	task chk(input [9:0] e, g);
		begin
			num_checks = num_checks + 1;
			if (e !== g) begin
				n_errors = n_errors + 1;
				$display("ERROR bit record expected %h seen %h", e, g);
			end
		end
	endtask
	task t_normal;
		reg [7:0] ex;
		begin
			u_src.send(NRM_D, NRM_M, 1'h0, 8);
			repeat (10) @(posedge clk);
			chk(10'h008, nb);
			for (i = 0; i < 8; i = i + 1) begin
				// Marker bits 0 and 5 restart the count.
				ex = (i < 5) ? i[7:0] : i[7:0] - 8'h05;
				chk({NRM_D[i], NRM_M[i], ex}, got[i]);
			end
			chk(10'h001, {9'h000, aligned});
		end
	endtask
	task t_symbol;
		begin
			u_src.send(8'h0A, 8'h00, 1'h1, 4);
			repeat (10) @(posedge clk);
			for (i = 0; i < 4; i = i + 1)
				chk({8'h0A >> i, 9'h100}, got[i + 8]);
		end
	endtask
	task summarize;
		begin
			$display("checks %0d errors %0d", num_checks, n_errors);
			if (n_errors == 0 && num_checks > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'h1;
		repeat (8) @(posedge clk);
		#3 t_normal;
		@(posedge clk) symbol_mode <= 1'h1;
		repeat (4) @(posedge clk);
		#3 t_symbol;
		summarize;
	end
endmodule // tb_esdc_capture
